// File: common/fem_map.vh
`ifndef FEM_MAP_VH
`define FEM_MAP_VH
// register byte offsets
`define FEM_OFS_CTRL      8'h00
`define FEM_OFS_ICMP      8'h04
`define FEM_OFS_SPORT_CFG 8'h08
`define FEM_OFS_SPORT_BND 8'h0C
`define FEM_OFS_DPORT_CFG 8'h10
`define FEM_OFS_DPORT_BND 8'h14
`define FEM_OFS_FLAGS     8'h18
`define FEM_OFS_STATUS    8'h1C
`define FEM_OFS_HIT_CNT   8'h20
`define FEM_OFS_MISS_CNT  8'h24
// protocol selection codes
`define FEM_PROTO_ANY     2'h0
`define FEM_PROTO_ICMP    2'h1
`define FEM_PROTO_UDP     2'h2
`define FEM_PROTO_TCP     2'h3
// port criterion modes
`define FEM_PMODE_ANY     2'h0
`define FEM_PMODE_EXACT   2'h1
`define FEM_PMODE_RANGE   2'h2
// flag criterion codes
`define FEM_FLAG_CLEAR    2'h0
`define FEM_FLAG_SET      2'h1
`define FEM_FLAG_ANY      2'h2
// field positions
`define FEM_CTRL_PROTO_LSB 0
`define FEM_CTRL_EN_BIT    2
`define FEM_ICMP_TSPEC_BIT 0
`define FEM_ICMP_CSPEC_BIT 1
`define FEM_ICMP_TVAL_LSB  8
`define FEM_ICMP_CVAL_LSB  16
`define FEM_BND_LO_LSB     0
`define FEM_BND_HI_LSB     16
// reset values
`define FEM_RST_CTRL       3'h0
`define FEM_RST_FLAGS      12'hAAA
`define FEM_RST_ICMP       24'h000000
`define FEM_RST_BND        32'h00000000
`endif

// File: hdl/fem_l4_matcher.v
// Chosen here: the register offsets and the plain strobed port.
`timescale 1ns/10ps
`include "fem_map.vh"

module fem_l4_matcher #(
    parameter AW = 8,
    parameter CW = 16
) (
    // clock and reset
    input  wire          clk_i,
    input  wire          sys_rst_i,
    // register port
    input  wire [AW-1:0] reg_addr_i,
    input  wire [31:0]   reg_wdata_i,
    input  wire          reg_wr_i,
    input  wire          reg_rd_i,
    output wire [31:0]   reg_rdata_o,
    // parsed header fields
    input  wire          hdr_valid_i,
    input  wire [1:0]    hdr_proto_i,
    input  wire [7:0]    hdr_icmp_type_i,
    input  wire [7:0]    hdr_icmp_code_i,
    input  wire [15:0]   hdr_sport_i,
    input  wire [15:0]   hdr_dport_i,
    input  wire [5:0]    hdr_tcp_flags_i,
    // match result
    output wire          res_valid_o,
    output wire          res_hit_o
);

    //--------------------------------------------------------------
    // helper functions
    //--------------------------------------------------------------

    // both tests are pure decoders used more than once; as functions the
    // source and destination paths cannot drift apart
    // port criterion test, shared by source and destination
    // exact mode reuses the low bound as its value, saving a register
    function port_ok;
        input [1:0]  mode;
        input [15:0] lo;
        input [15:0] hi;
        input [15:0] port;
        begin
            case (mode)
                `FEM_PMODE_ANY: begin
                    port_ok = 1'b1;
                end
                `FEM_PMODE_EXACT: begin
                    port_ok = (port == lo);
                end
                `FEM_PMODE_RANGE: begin
                    // inverted bounds never hit
                    port_ok = (lo <= hi) && (port >= lo) && (port <= hi);
                end
                default: begin
                    port_ok = 1'b0; // reserved mode code never hits
                end
            endcase
        end
    endfunction

    // three-way flag test
    function flag_ok;
        input [1:0] crit;
        input       bit_in;
        begin
            case (crit)
                `FEM_FLAG_CLEAR: begin
                    flag_ok = ~bit_in;
                end
                `FEM_FLAG_SET: begin
                    flag_ok = bit_in;
                end
                // codes 2 and 3 both mean don't-care
                default: begin
                    flag_ok = 1'b1;
                end
            endcase
        end
    endfunction

    //--------------------------------------------------------------
    // configuration registers
    //--------------------------------------------------------------

    // register map, one 32-bit word per offset, narrow fields in the low bits:
    //   0x00 entry control: [1:0] protocol selection, [2] entry enable
    //   0x04 icmp: [0] type specific, [1] code specific, [15:8] type, [23:16] code
    //   0x08 / 0x10 source / destination port mode: any, exact, range, reserved
    //   0x0C / 0x14 port bounds: [15:0] low bound or exact value, [31:16] high
    //   0x18 flag criteria, two bits per flag: clear, set, don't-care
    //   0x1C status, read only: hit of the current result cycle (zero without a result), result seen, live hit of the inputs
    //   0x20 / 0x24 hit and miss counters, read only, any write clears
    // upper bits of narrow registers are not stored and read back as zero
    reg  [2:0]  ctrl_reg;
    reg  [23:0] icmp_reg;
    reg  [1:0]  sport_mode_reg;
    reg  [31:0] sport_bnd_reg;
    reg  [1:0]  dport_mode_reg;
    reg  [31:0] dport_bnd_reg;
    reg  [11:0] flags_reg;
    reg  [CW-1:0] hit_cnt_reg;
    reg  [CW-1:0] miss_cnt_reg;
    reg  [31:0] rdata_reg;
    reg         res_valid_reg;
    reg         res_hit_reg;
    reg         seen_reg;

    wire [1:0]  ent_proto  = ctrl_reg[`FEM_CTRL_PROTO_LSB +: 2];
    wire        ent_en     = ctrl_reg[`FEM_CTRL_EN_BIT];
    wire        tspec      = icmp_reg[`FEM_ICMP_TSPEC_BIT];
    wire        cspec      = icmp_reg[`FEM_ICMP_CSPEC_BIT];
    wire [7:0]  tval       = icmp_reg[`FEM_ICMP_TVAL_LSB +: 8];
    wire [7:0]  cval       = icmp_reg[`FEM_ICMP_CVAL_LSB +: 8];
    wire [15:0] sport_lo   = sport_bnd_reg[`FEM_BND_LO_LSB +: 16];
    wire [15:0] sport_hi   = sport_bnd_reg[`FEM_BND_HI_LSB +: 16];
    wire [15:0] dport_lo   = dport_bnd_reg[`FEM_BND_LO_LSB +: 16];
    wire [15:0] dport_hi   = dport_bnd_reg[`FEM_BND_HI_LSB +: 16];

    // write decode; writes to status or unmapped offsets are dropped
    always @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            ctrl_reg       <= `FEM_RST_CTRL;
            icmp_reg       <= `FEM_RST_ICMP;
            sport_mode_reg <= `FEM_PMODE_ANY;
            sport_bnd_reg  <= `FEM_RST_BND;
            dport_mode_reg <= `FEM_PMODE_ANY;
            dport_bnd_reg  <= `FEM_RST_BND;
            flags_reg      <= `FEM_RST_FLAGS;
        end else if (reg_wr_i) begin
            case (reg_addr_i)
                `FEM_OFS_CTRL: begin
                    ctrl_reg <= reg_wdata_i[2:0];
                end
                `FEM_OFS_ICMP: begin
                    icmp_reg <= reg_wdata_i[23:0];
                end
                `FEM_OFS_SPORT_CFG: begin
                    sport_mode_reg <= reg_wdata_i[1:0];
                end
                `FEM_OFS_SPORT_BND: begin
                    sport_bnd_reg <= reg_wdata_i;
                end
                `FEM_OFS_DPORT_CFG: begin
                    dport_mode_reg <= reg_wdata_i[1:0];
                end
                `FEM_OFS_DPORT_BND: begin
                    dport_bnd_reg <= reg_wdata_i;
                end
                `FEM_OFS_FLAGS: begin
                    flags_reg <= reg_wdata_i[11:0];
                end
                default: begin
                    ctrl_reg <= ctrl_reg;
                end
            endcase
        end
    end

    //--------------------------------------------------------------
    // criterion evaluation
    //--------------------------------------------------------------

    // frame protocol must agree with the entry's selection
    wire proto_ok = (ent_proto == `FEM_PROTO_ANY) || (hdr_proto_i == ent_proto);

    // icmp criteria only count for an icmp entry
    wire icmp_type_ok = ~tspec || (hdr_icmp_type_i == tval);
    wire icmp_code_ok = ~cspec || (hdr_icmp_code_i == cval);
    wire icmp_ok      = (ent_proto != `FEM_PROTO_ICMP) || (icmp_type_ok && icmp_code_ok);

    // port criteria only count for udp and tcp entries; an icmp or any
    // entry has no meaningful port fields to compare against
    // port criteria only count for udp and tcp entries
    wire l4_port_ent  = (ent_proto == `FEM_PROTO_UDP) || (ent_proto == `FEM_PROTO_TCP);
    wire sport_ok     = port_ok(sport_mode_reg, sport_lo, sport_hi, hdr_sport_i);
    wire dport_ok     = port_ok(dport_mode_reg, dport_lo, dport_hi, hdr_dport_i);
    wire ports_ok     = ~l4_port_ent || (sport_ok && dport_ok);

    // bit 1 of each criterion pair set means don't-care, so the reset
    // value leaves every flag ignored
    // per-flag tests: bit 0 fin, 1 syn, 2 rst, 3 psh, 4 ack, 5 urg
    wire [5:0] flag_pass;
    wire [5:0] flag_any;
    genvar gi;
    generate
        for (gi = 0; gi < 6; gi = gi + 1) begin : g_flag
            assign flag_pass[gi] = flag_ok(flags_reg[2*gi +: 2], hdr_tcp_flags_i[gi]);
            assign flag_any[gi]  = flags_reg[2*gi+1];
        end
    endgenerate

    // a non-any flag demands a tcp frame on a tcp entry; a cheaper
    // design would ignore flags on other entries, but that could
    // let a udp frame pass a flag filter
    wire all_any  = &flag_any;
    wire is_tcp   = (hdr_proto_i == `FEM_PROTO_TCP) && (ent_proto == `FEM_PROTO_TCP);
    wire flags_ok = all_any || (is_tcp && (&flag_pass));

    // every enabled criterion at once
    wire hit_next = ent_en && proto_ok && icmp_ok && ports_ok && flags_ok;

    //--------------------------------------------------------------
    // result stage
    //--------------------------------------------------------------

    // the match is one register deep: config and header are both taken at
    // the edge where the valid header is seen, so a config write in that
    // same cycle only applies from the next header on
    // result registered one cycle after the valid header
    always @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            res_valid_reg <= 1'b0;
            res_hit_reg   <= 1'b0;
        end else begin
            res_valid_reg <= hdr_valid_i;
            if (hdr_valid_i) begin
                res_hit_reg <= hit_next;
            end else begin
                res_hit_reg <= 1'b0;
            end
        end
    end

    assign res_valid_o = res_valid_reg;
    assign res_hit_o   = res_hit_reg;

    //--------------------------------------------------------------
    // statistics
    //--------------------------------------------------------------

    // counters saturate so software never sees a wrap to zero
    wire cnt_clr_hit  = reg_wr_i && (reg_addr_i == `FEM_OFS_HIT_CNT);
    wire cnt_clr_miss = reg_wr_i && (reg_addr_i == `FEM_OFS_MISS_CNT);
    wire hit_ev       = res_valid_reg && res_hit_reg;
    wire miss_ev      = res_valid_reg && ~res_hit_reg;

    // an event in the clearing cycle counts as one
    // so a frame landing on the clear is never lost
    always @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            hit_cnt_reg  <= {CW{1'b0}};
            miss_cnt_reg <= {CW{1'b0}};
            seen_reg     <= 1'b0;
        end else begin
            if (cnt_clr_hit) begin
                hit_cnt_reg <= {{(CW-1){1'b0}}, hit_ev};
            end else if (hit_ev && ~&hit_cnt_reg) begin
                hit_cnt_reg <= hit_cnt_reg + {{(CW-1){1'b0}}, 1'b1};
            end
            if (cnt_clr_miss) begin
                miss_cnt_reg <= {{(CW-1){1'b0}}, miss_ev};
            end else if (miss_ev && ~&miss_cnt_reg) begin
                miss_cnt_reg <= miss_cnt_reg + {{(CW-1){1'b0}}, 1'b1};
            end
            if (res_valid_reg) begin
                seen_reg <= 1'b1;
            end
        end
    end

    //--------------------------------------------------------------
    // read path
    //--------------------------------------------------------------

    reg [31:0] rd_mux;

    // the status live bit is combinational from the header pins, so it only
    // means something while the parser holds a header on them
    // read mux; unmapped offsets answer zero
    always @* begin
        rd_mux = 32'h00000000;
        case (reg_addr_i)
            `FEM_OFS_CTRL: begin
                rd_mux[2:0] = ctrl_reg;
            end
            `FEM_OFS_ICMP: begin
                rd_mux[23:0] = icmp_reg;
            end
            `FEM_OFS_SPORT_CFG: begin
                rd_mux[1:0] = sport_mode_reg;
            end
            `FEM_OFS_SPORT_BND: begin
                rd_mux = sport_bnd_reg;
            end
            `FEM_OFS_DPORT_CFG: begin
                rd_mux[1:0] = dport_mode_reg;
            end
            `FEM_OFS_DPORT_BND: begin
                rd_mux = dport_bnd_reg;
            end
            `FEM_OFS_FLAGS: begin
                rd_mux[11:0] = flags_reg;
            end
            `FEM_OFS_STATUS: begin
                rd_mux[0] = res_hit_reg;
                rd_mux[1] = seen_reg;
                rd_mux[2] = hit_next; // live view of the current inputs
            end
            `FEM_OFS_HIT_CNT: begin
                rd_mux[CW-1:0] = hit_cnt_reg;
            end
            `FEM_OFS_MISS_CNT: begin
                rd_mux[CW-1:0] = miss_cnt_reg;
            end
            default: begin
                rd_mux = 32'h00000000;
            end
        endcase
    end

    // read data stand only in the cycle after the strobe
    always @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            rdata_reg <= 32'h00000000;
        end else if (reg_rd_i) begin
            rdata_reg <= rd_mux;
        end else begin
            rdata_reg <= 32'h00000000;
        end
    end

    assign reg_rdata_o = rdata_reg;

endmodule // fem_l4_matcher

// File: tb/fem_l4_matcher_props.sv
`timescale 1ns/10ps
module fem_l4_matcher_props #(
    parameter AW = 8
) (
    // clock and reset
    input wire          clk_i,
    input wire          sys_rst_i,
    // register port
    input wire [AW-1:0] reg_addr_i,
    input wire [31:0]   reg_wdata_i,
    input wire          reg_wr_i,
    // header and result
    input wire          hdr_valid_i,
    input wire [1:0]    hdr_proto_i,
    input wire          res_valid_o,
    input wire          res_hit_o
);
    // --------------------------------------------
    // shadow of entry control and flag criteria
    // --------------------------------------------
    reg  [2:0]  ctl_reg;
    reg  [11:0] flg_reg;
    wire        all_any = (flg_reg & 12'hAAA) == 12'hAAA;
    wire        tcp_both = (hdr_proto_i == 2'h3) && (ctl_reg[1:0] == 2'h3);
    // shadow follows the same edge as the design so no skew between them
    always @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            ctl_reg <= 3'h0;
            flg_reg <= 12'hAAA;
        end else if (reg_wr_i) begin
            if (reg_addr_i == 8'h00) ctl_reg <= reg_wdata_i[2:0];
            if (reg_addr_i == 8'h18) flg_reg <= reg_wdata_i[11:0];
        end
    end
    default clocking @(posedge clk_i); endclocking
    default disable iff (sys_rst_i);
    AST_RES_LAT: assert property (hdr_valid_i |=> res_valid_o)
        else $error("no result one cycle after header");
    AST_NO_SPUR: assert property (!hdr_valid_i |=> !res_valid_o)
        else $error("result without header");
    AST_HIT_QUAL: assert property (!res_valid_o |-> !res_hit_o)
        else $error("hit outside result cycle");
    AST_DIS_MISS: assert property (hdr_valid_i && !ctl_reg[2] |=> !res_hit_o)
        else $error("disabled entry hit");
    AST_PROTO_MISS: assert property (hdr_valid_i && ctl_reg[1:0] != 2'h0
        && hdr_proto_i != ctl_reg[1:0] |=> !res_hit_o) else $error("protocol mismatch hit");
    AST_FLAG_TCP: assert property (hdr_valid_i && !all_any && !tcp_both |=> !res_hit_o)
        else $error("flag criteria hit a non tcp frame");
    AST_ANY_HIT: assert property (hdr_valid_i && ctl_reg == 3'h4 && all_any |=> res_hit_o)
        else $error("all don't-care entry missed");
    AST_RST_CLR: assert property ($fell(sys_rst_i) |-> !res_valid_o && !res_hit_o)
        else $error("result not clear after reset");
    COV_HIT: cover property (res_valid_o && res_hit_o);
    COV_MISS: cover property (res_valid_o && !res_hit_o);
    COV_B2B: cover property (hdr_valid_i [*2]);
endmodule // fem_l4_matcher_props

bind fem_l4_matcher fem_l4_matcher_props #(.AW(AW)) u_props (
    .clk_i(clk_i), .sys_rst_i(sys_rst_i), .reg_addr_i(reg_addr_i),
    .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .hdr_valid_i(hdr_valid_i),
    .hdr_proto_i(hdr_proto_i), .res_valid_o(res_valid_o), .res_hit_o(res_hit_o)
);

// File: tb/fem_l4_matcher_tb.sv
`timescale 1ns/10ps
module fem_l4_matcher_tb;
    reg          clk_i = 1'b0;
    reg          sys_rst_i = 1'b1;
    reg  [7:0]   reg_addr_i = 8'h00;
    reg  [31:0]  reg_wdata_i = 32'h0;
    reg          reg_wr_i = 1'b0;
    reg          reg_rd_i = 1'b0;
    wire [31:0]  reg_rdata_o;
    reg          req = 1'b0;
    reg  [55:0]  fld = 56'h0;
    wire         hv;
    wire         rv;
    wire         rh;
    wire [55:0]  hf;
    integer      seed = 25309;
    integer      n_errors = 0;
    integer      comparisons = 0;
    integer      n_hit = 0;
    integer      n_miss = 0;
    integer      cyc = 0;
    integer      i;
    reg          rd_pend = 1'b0;
    reg          e;
    reg  [31:0]  cfg [0:7];
    reg  [31:0]  r;
    reg  [55:0]  f;
    logic        hq [$];
    logic [31:0] rq [$];
    // --------------------------------------------
    // clock, partner and design
    // --------------------------------------------
    always #25 clk_i = ~clk_i;
    fem_parser_model u_fem_parser_model (.clk_i(clk_i), .req_i(req), .fld_i(fld),
        .hdr_valid_o(hv), .hdr_o(hf));
    fem_l4_matcher u_fem_l4_matcher (.clk_i(clk_i), .sys_rst_i(sys_rst_i),
        .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i),
        .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o), .hdr_valid_i(hv),
        .hdr_proto_i(hf[55:54]), .hdr_icmp_type_i(hf[53:46]), .hdr_icmp_code_i(hf[45:38]),
        .hdr_sport_i(hf[37:22]), .hdr_dport_i(hf[21:6]), .hdr_tcp_flags_i(hf[5:0]),
        .res_valid_o(rv), .res_hit_o(rh));
    // port criterion: any, exact or inclusive range; mode 3 never hits
    function pm(input [31:0] md, input [31:0] b, input [15:0] p);
        pm = md[1:0] == 2'h0 || (md[1:0] == 2'h1 && p == b[15:0])
            || (md[1:0] == 2'h2 && p >= b[15:0] && p <= b[31:16]);
    endfunction
    // expected hit from the bench's own copy of the entry
    function exp_hit(input [55:0] x);
        integer k;
        reg [1:0] ep;
        begin
            ep = cfg[0][1:0];
            exp_hit = cfg[0][2] && (ep == 2'h0 || ep == x[55:54]);
            if (ep == 2'h1 && cfg[1][0] && x[53:46] != cfg[1][15:8]) exp_hit = 1'b0;
            if (ep == 2'h1 && cfg[1][1] && x[45:38] != cfg[1][23:16]) exp_hit = 1'b0;
            if (ep[1] && !(pm(cfg[2], cfg[3], x[37:22]) && pm(cfg[4], cfg[5], x[21:6])))
                exp_hit = 1'b0;
            for (k = 0; k < 6; k = k + 1)
                if (!cfg[6][2*k+1] && (ep != 2'h3 || x[55:54] != 2'h3 || x[k] != cfg[6][2*k]))
                    exp_hit = 1'b0;
        end
    endfunction
    // --------------------------------------------
    // bus and header tasks
    // --------------------------------------------
    task acc(input [7:0] a, input [31:0] d, input w);
        begin
            @(posedge clk_i);
            if (!w) rq.push_back(d);
            reg_addr_i <= a;
            reg_wdata_i <= d;
            reg_wr_i <= w;
            reg_rd_i <= !w;
            @(posedge clk_i);
            reg_wr_i <= 1'b0;
            reg_rd_i <= 1'b0;
        end
    endtask
    task cfgw(input [7:0] a, input [31:0] d, input [31:0] m);
        begin
            cfg[a[4:2]] = d & m;
            acc(a, d, 1'b1);
            acc(a, d & m, 1'b0);
        end
    endtask
    // headers with random gaps, so back-to-back and idle cycles both occur
    task burst(input integer n);
        begin
            repeat (n) begin
                @(posedge clk_i);
                r = $random(seed);
                f = {$random(seed), r[23:0]};
                f[53:38] = f[53:38] & 16'h0303;
                f[37:22] = f[37:22] & 16'h001F;
                f[21:6] = {11'h000, r[28:24]};
                req <= r[30] | r[31];
                fld <= f;
                if (r[30] | r[31]) begin
                    hq.push_back(exp_hit(f));
                    if (exp_hit(f)) n_hit = n_hit + 1;
                    else n_miss = n_miss + 1;
                end
            end
            @(posedge clk_i);
            req <= 1'b0;
        end
    endtask
    task summarize;
        begin
            if (hq.size() != 0 || rq.size() != 0) begin
                n_errors = n_errors + 1;
                $display("MISMATCH %0t results or read answers never arrived", $time);
            end
            if (n_errors == 0 && comparisons > 0)
                $display("ALL TESTS PASSED");
            else
                $display("TESTS FAILED");
            $finish;
        end
    endtask
    // monitor: oldest note against each result or read answer
    always @(posedge clk_i) begin
        cyc <= cyc + 1;
        if (rv === 1'b1) begin
            e = (hq.size() != 0) ? hq.pop_front() : 1'bx;
            comparisons = comparisons + 1;
            if (rh !== e) begin
                n_errors = n_errors + 1;
                $display("MISMATCH %0t hit %b expected %b", $time, rh, e);
            end
        end
        if (rd_pend) begin
            comparisons = comparisons + 1;
            if (reg_rdata_o !== rq[0]) begin
                n_errors = n_errors + 1;
                $display("MISMATCH %0t read %h expected %h", $time, reg_rdata_o, rq[0]);
            end
            rq.delete(0);
        end
        rd_pend <= reg_rd_i;
        if (cyc == 20000) begin
            n_errors = n_errors + 1;
            summarize;
        end
    end
    // --------------------------------------------
    // main sequence
    // --------------------------------------------
    initial begin
        for (i = 0; i < 8; i = i + 1) cfg[i] = (i == 6) ? 32'h0000_0AAA : 32'h0;
        repeat (5) @(posedge clk_i);
        sys_rst_i <= 1'b0;
        for (i = 0; i < 11; i = i + 1) acc(i * 4, (i == 6) ? 32'h0AAA : 32'h0, 1'b0);
        acc(8'h28, 32'hFFFF_FFFF, 1'b1);
        acc(8'h28, 32'h0, 1'b0);
        cfgw(8'h00, 32'h4, 32'h7);
        burst(8);
        for (i = 0; i < 60; i = i + 1) begin
            r = $random(seed);
            r[2] = r[2] | r[3];
            cfgw(8'h00, r, 32'h7);
            cfgw(8'h04, $random(seed) & 32'hF003_0303, 32'h00FF_FF03);
            cfgw(8'h08, $random(seed), 32'h3);
            cfgw(8'h0C, $random(seed) & 32'h001F_001F, 32'hFFFF_FFFF);
            cfgw(8'h10, $random(seed), 32'h3);
            cfgw(8'h14, $random(seed) & 32'h001F_001F, 32'hFFFF_FFFF);
            cfgw(8'h18, $random(seed) | ($random(seed) & 32'hAAA), 32'hFFF);
            burst(10);
        end
        repeat (3) @(posedge clk_i);
        acc(8'h20, n_hit, 1'b0);
        acc(8'h24, n_miss, 1'b0);
        acc(8'h20, 32'h0, 1'b1);
        acc(8'h20, 32'h0, 1'b0);
        // second reset in mid-run must restore the entry defaults
        repeat (3) @(posedge clk_i);
        sys_rst_i <= 1'b1;
        repeat (2) @(posedge clk_i);
        sys_rst_i <= 1'b0;
        n_hit = 0;
        n_miss = 0;
        for (i = 0; i < 8; i = i + 1) cfg[i] = (i == 6) ? 32'h0000_0AAA : 32'h0;
        acc(8'h00, 32'h0, 1'b0);
        acc(8'h18, 32'h0AAA, 1'b0);
        burst(6);
        repeat (4) @(posedge clk_i);
        acc(8'h24, n_miss, 1'b0);
        acc(8'h20, n_hit, 1'b0);
        repeat (2) @(posedge clk_i);
        summarize;
    end
endmodule // fem_l4_matcher_tb

// File: tb/fem_parser_model.sv
`timescale 1ns/10ps
module fem_parser_model (
    // request from bench
    input  wire        clk_i,
    input  wire        req_i,
    input  wire [55:0] fld_i,
    // parsed header toward the matcher
    output reg         hdr_valid_o = 1'b0,
    output reg  [55:0] hdr_o = 56'h0
);
    // one header per request; idle fields flip so stale data never looks valid
    always @(posedge clk_i) begin
        hdr_valid_o <= req_i;
        hdr_o       <= req_i ? fld_i : ~hdr_o;
    end
endmodule // fem_parser_model
